// File: verilog/slfc_pkg.sv
// Purpose: Shared constants and types for the segment panel frame control core
// Assumes: APB slave with 32-bit data, one 50 MHz clock
// Notes: All offsets are byte addresses of aligned words
package slfc_pkg;
    localparam int CLK_HZ = 50000000; // Core clock rate
    // Register byte offsets
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_DISP = 12'h004;
    localparam logic [11:0] OFF_BLINK_ANIMATION_CONTROL = 12'h00c;
    localparam logic [11:0] OFF_STATUS = 12'h010;
    localparam logic [11:0] OFF_ANIMATION_PATTERN_FIRST = 12'h014;
    localparam logic [11:0] OFF_ANIMATION_PATTERN_SECOND = 12'h018;
    localparam logic [11:0] OFF_IF = 12'h01c;
    localparam logic [11:0] OFF_IFS = 12'h020;
    localparam logic [11:0] OFF_IFC = 12'h024;
    localparam logic [11:0] OFF_IEN = 12'h028;
    localparam logic [11:0] OFF_CLKCFG = 12'h030;
    localparam logic [11:0] OFF_SEGD0 = 12'h040;
    localparam logic [11:0] OFF_COMMON_LEVEL_DATA = 12'h0b4;
    localparam int NUM_SEGD = 4; // Segment data words below the common word
    localparam int PRE_BASE_LOG = 4; // Smallest prescale is divide by 16
    // Update timing selections
    typedef enum logic [1:0] {
        UPD_REGULAR = 2'h0,
        UPD_COUNTER_EVENT = 2'h1,
        UPD_FRAME_ALIGNED = 2'h2,
        UPD_RESERVED = 2'h3
    } slfc_upd_e;
    // Direct level field encoding
    typedef enum logic [1:0] {
        LVL_STATIC = 2'h0,
        LVL_HALF = 2'h1,
        LVL_THIRD = 2'h2,
        LVL_QUARTER = 2'h3
    } slfc_level_e;
    // Control word: [0] enable, [2:1] update timing, [3] direct level
    typedef struct packed {
        logic direct_level_control;
        slfc_upd_e update_timing_select;
        logic enable;
    } slfc_ctrl_s;
    // Display word: [2:0] mux, [4:3] bias, [5] ref, [6] supply, [11:7] contrast
    typedef struct packed {
        logic [4:0] contrast_level;
        logic supply_source_select;
        logic contrast_reference_select;
        logic [1:0] bias;
        logic [2:0] mux;
    } slfc_disp_s;
    // Counter word: [0] enable, [2:1] prescale, [8:3] top
    typedef struct packed {
        logic [5:0] frame_counter_top;
        logic [1:0] frame_counter_prescale;
        logic frame_counter_enable;
    } slfc_blink_animation_control_s;
    // Clock word: [1:0] prescale, [4:2] frame rate divider, [7:5] boost divider
    typedef struct packed {
        logic [2:0] boost_update_divider;
        logic [2:0] frame_rate_divider;
        logic [1:0] panel_prescale;
    } slfc_clkcfg_s;
    localparam logic [11:0] DISP_RESET = 12'hf80; // Maximum contrast
endpackage

// File: verilog/slfc_frame_control.sv
// Purpose: Frame timing, data update and frame counter of a segment panel driver
// Assumes: low_freq_clock_a is an asynchronous pin sampled on clk_i
// Notes: Driver-side logic runs on enable pulses derived from that pin
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module slfc_frame_control (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic low_freq_clock_a,
    output logic contrast_reference_select_o,
    output logic supply_source_select_o,
    output logic [4:0] contrast_level_o,
    output logic boost_update_tick_o,
    output logic driver_tick_o,
    output logic frame_start_o,
    output logic counter_event_o,
    output logic fc_irq_o,
    output logic [127:0] seg_level_o,
    output logic [31:0] common_level_o,
    output logic [7:0] anim_first_o,
    output logic [7:0] anim_second_o,
    output logic [8:0] blink_animation_control_drv_o
);
    // Pow2 minus one mask, used by several dividers
    function automatic logic [6:0] low_mask(input logic [2:0] e);
        low_mask = 7'((8'h01 << e) - 8'h01);
    endfunction

    slfc_pkg::slfc_ctrl_s ctrl; // Control word
    slfc_pkg::slfc_disp_s disp; // Display word
    slfc_pkg::slfc_blink_animation_control_s blink_animation_control; // Counter word, buffered
    slfc_pkg::slfc_clkcfg_s clkcfg; // Clock unit word
    logic [31:0] segd [0:slfc_pkg::NUM_SEGD]; // Buffered data, last is common
    logic [31:0] segd_drv [0:slfc_pkg::NUM_SEGD]; // Driver-side copies
    logic [7:0] animation_pattern_first, animation_pattern_second; // Buffered patterns
    logic fc_flag, fc_ien; // Counter event flag and enable
    logic pending; // Buffered data awaiting transfer
    logic lf_s1, lf_s2, lf_s3; // Pin synchroniser and edge history
    logic lf_tick, pre_tick, drv_tick, frm_tick, fc_evt; // Internal pulses
    logic [6:0] pre_cnt, boost_cnt; // Prescale and boost counters
    logic [2:0] frame_rate_divider_cnt, fcp_cnt; // Driver divider and counter prescale
    logic [3:0] phase_cnt, phase_last; // Position inside a frame
    logic [5:0] fc_cnt; // Frame counter value
    logic xfer; // Transfer strobe to driver side
    logic acc, wr, sync_wr; // Bus strobes
    logic [31:0] next_rdata; // Read mux result
    logic next_err; // Unmapped address

    assign acc = psel_i && penable_i && pready_o;
    assign wr = acc && pwrite_i;
    assign sync_wr = wr && (paddr_i == slfc_pkg::OFF_BLINK_ANIMATION_CONTROL || paddr_i == slfc_pkg::OFF_ANIMATION_PATTERN_FIRST
        || paddr_i == slfc_pkg::OFF_ANIMATION_PATTERN_SECOND || paddr_i == slfc_pkg::OFF_COMMON_LEVEL_DATA
        || (paddr_i >= slfc_pkg::OFF_SEGD0 && paddr_i <= slfc_pkg::OFF_SEGD0 + 12'h00c));

    // Read decode and unmapped detection
    always_comb begin
        next_rdata = 32'h0;
        next_err = 1'b0;
        case (paddr_i)
            slfc_pkg::OFF_CTRL: next_rdata = 32'(ctrl);
            slfc_pkg::OFF_DISP: next_rdata = 32'(disp);
            slfc_pkg::OFF_BLINK_ANIMATION_CONTROL: next_rdata = 32'(blink_animation_control);
            slfc_pkg::OFF_STATUS: next_rdata = {30'h0, ctrl.enable, pending};
            slfc_pkg::OFF_ANIMATION_PATTERN_FIRST: next_rdata = {24'h0, animation_pattern_first};
            slfc_pkg::OFF_ANIMATION_PATTERN_SECOND: next_rdata = {24'h0, animation_pattern_second};
            slfc_pkg::OFF_IF: next_rdata = {31'h0, fc_flag};
            slfc_pkg::OFF_IFS, slfc_pkg::OFF_IFC: next_rdata = 32'h0;
            slfc_pkg::OFF_IEN: next_rdata = {31'h0, fc_ien};
            slfc_pkg::OFF_CLKCFG: next_rdata = 32'(clkcfg);
            slfc_pkg::OFF_COMMON_LEVEL_DATA: next_rdata = segd[slfc_pkg::NUM_SEGD];
            default: begin
                if (paddr_i >= slfc_pkg::OFF_SEGD0 && paddr_i <= slfc_pkg::OFF_SEGD0 + 12'h00c
                    && paddr_i[1:0] == 2'h0) begin
                    next_rdata = segd[paddr_i[3:2]];
                end else begin
                    next_err = 1'b1;
                end
            end
        endcase
    end

    // APB answer: ready in the first access cycle
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0;
        end else begin
            pready_o <= psel_i && !penable_i;
            if (psel_i && !penable_i) begin
                pslverr_o <= next_err;
                prdata_o <= pwrite_i ? 32'h0 : next_rdata;
            end else if (acc) begin
                pslverr_o <= 1'b0;
            end
        end
    end

    // Plain control words written by software
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ctrl <= '0;
            disp <= slfc_pkg::slfc_disp_s'(slfc_pkg::DISP_RESET);
            clkcfg <= '0;
            fc_ien <= 1'b0;
        end else if (wr) begin
            case (paddr_i)
                slfc_pkg::OFF_CTRL: ctrl <= slfc_pkg::slfc_ctrl_s'(pwdata_i[3:0]);
                slfc_pkg::OFF_DISP: disp <= slfc_pkg::slfc_disp_s'(pwdata_i[11:0]);
                slfc_pkg::OFF_CLKCFG: clkcfg <= slfc_pkg::slfc_clkcfg_s'(pwdata_i[7:0]);
                slfc_pkg::OFF_IEN: fc_ien <= pwdata_i[0];
                default: ;
            endcase
        end
    end

    // Buffered words that are synchronised to the driver side
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            blink_animation_control <= '0;
            animation_pattern_first <= 8'h0;
            animation_pattern_second <= 8'h0;
            for (int i = 0; i <= slfc_pkg::NUM_SEGD; i++) segd[i] <= 32'h0;
        end else if (wr) begin
            if (paddr_i == slfc_pkg::OFF_BLINK_ANIMATION_CONTROL)
                blink_animation_control <= slfc_pkg::slfc_blink_animation_control_s'(pwdata_i[8:0]);
            if (paddr_i == slfc_pkg::OFF_ANIMATION_PATTERN_FIRST) animation_pattern_first <= pwdata_i[7:0];
            if (paddr_i == slfc_pkg::OFF_ANIMATION_PATTERN_SECOND) animation_pattern_second <= pwdata_i[7:0];
            if (paddr_i == slfc_pkg::OFF_COMMON_LEVEL_DATA) segd[slfc_pkg::NUM_SEGD] <= pwdata_i;
            if (paddr_i >= slfc_pkg::OFF_SEGD0 && paddr_i <= slfc_pkg::OFF_SEGD0 + 12'h00c)
                segd[paddr_i[3:2]] <= pwdata_i;
        end
    end

    // Pin synchroniser; the second and third stages feed the edge detect
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            lf_s1 <= 1'b0;
            lf_s2 <= 1'b0;
            lf_s3 <= 1'b0;
        end else begin
            lf_s1 <= low_freq_clock_a;
            lf_s2 <= lf_s1;
            lf_s3 <= lf_s2;
        end
    end
    assign lf_tick = lf_s2 && !lf_s3;

    // Panel prescaler and driver divider
    assign pre_tick = lf_tick
        && pre_cnt == low_mask(3'(clkcfg.panel_prescale) + 3'(slfc_pkg::PRE_BASE_LOG));
    assign drv_tick = pre_tick && frame_rate_divider_cnt == clkcfg.frame_rate_divider;
    always_ff @(posedge clk_i) begin
        if (srst_i || !ctrl.enable) begin
            pre_cnt <= 7'h0;
            frame_rate_divider_cnt <= 3'h0;
        end else if (lf_tick) begin
            pre_cnt <= pre_tick ? 7'h0 : pre_cnt + 7'h1;
            if (pre_tick) frame_rate_divider_cnt <= drv_tick ? 3'h0 : frame_rate_divider_cnt + 3'h1;
        end
    end

    // Last phase of a frame for each multiplex mode
    always_comb begin
        case (disp.mux)
            3'h0: phase_last = 4'h1;
            3'h1: phase_last = 4'h3;
            3'h2: phase_last = 4'h5;
            3'h3: phase_last = 4'h7;
            3'h4: phase_last = 4'hb;
            default: phase_last = 4'hf;
        endcase
    end
    assign frm_tick = drv_tick && phase_cnt == phase_last;

    // Position inside the frame
    always_ff @(posedge clk_i) begin
        if (srst_i || !ctrl.enable) begin
            phase_cnt <= 4'h0;
        end else if (drv_tick) begin
            phase_cnt <= frm_tick ? 4'h0 : phase_cnt + 4'h1;
        end
    end

    // Frame counter stepped at frame boundaries
    assign fc_evt = frm_tick && blink_animation_control.frame_counter_enable
        && fcp_cnt == 3'(low_mask({1'b0, blink_animation_control.frame_counter_prescale})) && fc_cnt == 6'h0;
    always_ff @(posedge clk_i) begin
        if (srst_i || !blink_animation_control.frame_counter_enable) begin
            fcp_cnt <= 3'h0;
            fc_cnt <= 6'h0;
        end else if (frm_tick) begin
            if (fcp_cnt == 3'(low_mask({1'b0, blink_animation_control.frame_counter_prescale}))) begin
                fcp_cnt <= 3'h0;
                fc_cnt <= (fc_cnt == 6'h0) ? blink_animation_control.frame_counter_top : fc_cnt - 6'h1;
            end else begin
                fcp_cnt <= fcp_cnt + 3'h1;
            end
        end
    end

    // Transfer point chosen by update timing
    always_comb begin
        case (ctrl.update_timing_select)
            slfc_pkg::UPD_REGULAR: xfer = pending && pre_tick;
            slfc_pkg::UPD_COUNTER_EVENT: xfer = pending && fc_evt;
            slfc_pkg::UPD_FRAME_ALIGNED: xfer = pending && frm_tick;
            default: xfer = 1'b0;
        endcase
    end

    // Pending flag: a new write wins over the transfer
    always_ff @(posedge clk_i) begin
        if (srst_i) pending <= 1'b0;
        else if (sync_wr) pending <= 1'b1;
        else if (xfer) pending <= 1'b0;
    end

    // Driver-side copies loaded only at transfer points
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            for (int i = 0; i <= slfc_pkg::NUM_SEGD; i++) segd_drv[i] <= 32'h0;
            anim_first_o <= 8'h0;
            anim_second_o <= 8'h0;
            blink_animation_control_drv_o <= 9'h0;
        end else if (xfer) begin
            for (int i = 0; i <= slfc_pkg::NUM_SEGD; i++) segd_drv[i] <= segd[i];
            anim_first_o <= animation_pattern_first;
            anim_second_o <= animation_pattern_second;
            blink_animation_control_drv_o <= 9'(blink_animation_control);
        end
    end

    // Line levels: direct fields or the common bias code
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            seg_level_o <= '0;
            common_level_o <= 32'h0;
        end else if (ctrl.direct_level_control) begin
            seg_level_o <= {segd_drv[3], segd_drv[2], segd_drv[1], segd_drv[0]};
            common_level_o <= segd_drv[slfc_pkg::NUM_SEGD];
        end else begin
            seg_level_o <= {64{disp.bias}};
            common_level_o <= {16{disp.bias}};
        end
    end

    // Event flag with set over clear, and gated request
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            fc_flag <= 1'b0;
        end else if (fc_evt || (wr && paddr_i == slfc_pkg::OFF_IFS && pwdata_i[0])) begin
            fc_flag <= 1'b1;
        end else if (wr && paddr_i == slfc_pkg::OFF_IFC && pwdata_i[0]) begin
            fc_flag <= 1'b0;
        end
    end

    // Boost update divider on the raw low-frequency edges
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            boost_cnt <= 7'h0;
        end else if (lf_tick) begin
            boost_cnt <= boost_cnt + 7'h1;
        end
    end

    // Registered outputs
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            contrast_reference_select_o <= 1'b0;
            supply_source_select_o <= 1'b0;
            contrast_level_o <= 5'h0;
            boost_update_tick_o <= 1'b0;
            driver_tick_o <= 1'b0;
            frame_start_o <= 1'b0;
            counter_event_o <= 1'b0;
            fc_irq_o <= 1'b0;
        end else begin
            contrast_reference_select_o <= disp.contrast_reference_select;
            supply_source_select_o <= disp.supply_source_select;
            contrast_level_o <= disp.contrast_level;
            boost_update_tick_o <= lf_tick
                && (boost_cnt & low_mask(clkcfg.boost_update_divider)) == 7'h0;
            driver_tick_o <= drv_tick;
            frame_start_o <= frm_tick;
            counter_event_o <= fc_evt;
            fc_irq_o <= fc_flag && fc_ien;
        end
    end

    sequence s_evt;
        counter_event_o;
    endsequence
    sequence s_req(logic f, logic e);
        ##1 (f && e);
    endsequence
    a_event_on_frame: assert property (@(posedge clk_i) disable iff (srst_i)
        counter_event_o |-> frame_start_o) else $error("counter event off frame start");
    a_event_sets_flag: assert property (@(posedge clk_i) disable iff (srst_i)
        s_evt |-> ##1 fc_flag) else $error("event did not set flag");
    a_irq_gated: assert property (@(posedge clk_i) disable iff (srst_i)
        fc_irq_o |-> $past(fc_ien)) else $error("request without enable");
    a_reload_top: assert property (@(posedge clk_i) disable iff (srst_i)
        fc_evt |=> fc_cnt == $past(blink_animation_control.frame_counter_top)) else $error("no reload");
    a_disabled_quiet: assert property (@(posedge clk_i) disable iff (srst_i)
        !blink_animation_control.frame_counter_enable |-> !fc_evt) else $error("event while disabled");
    a_mode01_hold: assert property (@(posedge clk_i) disable iff (srst_i)
        ctrl.update_timing_select == slfc_pkg::UPD_COUNTER_EVENT && xfer |-> fc_evt)
        else $error("mode 01 transfer off event");
    a_mode10_frame: assert property (@(posedge clk_i) disable iff (srst_i)
        ctrl.update_timing_select == slfc_pkg::UPD_FRAME_ALIGNED && xfer |-> frm_tick)
        else $error("mode 10 transfer off frame");
    a_frame_len: assert property (@(posedge clk_i) disable iff (srst_i)
        frm_tick && disp.mux == 3'h0 |-> $past(phase_cnt) == 4'h0 || !drv_tick
        || phase_cnt == 4'h1) else $error("static frame length wrong");
    a_xfer_copies: assert property (@(posedge clk_i) disable iff (srst_i)
        xfer |=> anim_first_o == $past(animation_pattern_first)) else $error("pattern not copied");
    a_direct_level: assert property (@(posedge clk_i) disable iff (srst_i)
        ctrl.direct_level_control |=> seg_level_o[1:0] == $past(segd_drv[0][1:0]))
        else $error("direct level not applied");
    a_irq_follow: assert property (@(posedge clk_i) disable iff (srst_i)
        s_req(fc_flag, fc_ien) |-> ##1 fc_irq_o) else $error("request missing");
endmodule
`default_nettype wire

// File: verification/slfc_panel_model.sv
// Purpose: Passive multiplexed segment glass at the far side of the core
// Assumes: One frame start pulse per frame, on or after its last driver tick
// Notes: Reports driver ticks per frame and the levels shown at frame end
`timescale 1ns/1ps
`default_nettype none
module slfc_panel_model (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic driver_tick_i,
    input wire logic frame_start_i,
    input wire logic [127:0] seg_level_i,
    input wire logic [31:0] common_level_i,
    output logic [4:0] ticks_per_frame_o,
    output logic [159:0] shown_levels_o
);
    logic [4:0] tick_count; // Ticks seen so far in this frame
    // Glass advances one multiplex period per tick and latches levels per frame
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tick_count <= 5'h00;
            ticks_per_frame_o <= 5'h00;
            shown_levels_o <= '0;
        end else if (frame_start_i) begin
            // Counts a tick landing in the same cycle as the frame end
            ticks_per_frame_o <= tick_count + {4'h0, driver_tick_i};
            shown_levels_o <= {common_level_i, seg_level_i};
            tick_count <= 5'h00;
        end else if (driver_tick_i) begin
            tick_count <= tick_count + 5'h01;
        end
    end
endmodule
`default_nettype wire

// File: verification/tb_segment_lcd_frame_control.sv
// Purpose: Self-checking bench of the frame control core over APB
// Assumes: Slow clock pin toggles every 40 ns, so 4 core cycles per slow rising edge
// Notes: Expected intervals are counted in core cycles from that rate
`timescale 1ns/1ps
`default_nettype none
module tb_segment_lcd_frame_control;
    logic clk_i = 1'b0, srst_i = 1'b1, lf_clk = 1'b0; // Clocks and reset
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, err; // APB request
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic pready_o, pslverr_o, cref, ssel, btick, dtick, fstart, cev, irq;
    logic [4:0] contrast, tpf;
    logic [127:0] seg_lvl;
    logic [159:0] shown;
    logic [31:0] com_lvl;
    logic [7:0] anim_a, anim_b;
    logic [8:0] bact; // Driver-side counter word
    int mismatches = 0, check_count = 0, c, nf;
    int ticks [6] = '{2, 4, 6, 8, 12, 16}; // Driver ticks per frame by mux
    // Core clock at 50 MHz and slow clock pin
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    initial begin
        forever #40 lf_clk = ~lf_clk;
    end
    slfc_frame_control i_dut (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .low_freq_clock_a(lf_clk), .contrast_reference_select_o(cref),
        .supply_source_select_o(ssel), .contrast_level_o(contrast),
        .boost_update_tick_o(btick), .driver_tick_o(dtick), .frame_start_o(fstart),
        .counter_event_o(cev), .fc_irq_o(irq), .seg_level_o(seg_lvl),
        .common_level_o(com_lvl), .anim_first_o(anim_a), .anim_second_o(anim_b),
        .blink_animation_control_drv_o(bact));
    slfc_panel_model i_panel (.clk_i(clk_i), .srst_i(srst_i), .driver_tick_i(dtick),
        .frame_start_i(fstart), .seg_level_i(seg_lvl), .common_level_i(com_lvl),
        .ticks_per_frame_o(tpf), .shown_levels_o(shown));
    // Verdict and end of run
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // One comparison
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // A used-up bound ends the run
    task automatic tmo(input logic bad);
        if (bad) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, 1'b0, 1'b1);
            stop_test();
        end
    endtask
    // APB transfer; request held until pready seen at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        tmo(n >= 20);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    // Waits for a pulse: 0 driver tick, 1 frame start, 2 counter event, 3 boost
    task automatic wait_ev(input int sel, output int cyc);
        logic s;
        cyc = 0;
        do begin
            @(posedge clk_i);
            cyc++;
            s = (sel == 0) ? dtick : (sel == 1) ? fstart : (sel == 2) ? cev : btick;
        end while (s !== 1'b1 && cyc < 40000);
        tmo(cyc >= 40000);
    endtask
    // Frame starts between two counter events
    task automatic fc_frames(output int n);
        wait_ev(2, c);
        n = 0;
        c = 0;
        do begin
            @(posedge clk_i);
            c++;
            if (fstart === 1'b1) n++;
        end while (cev !== 1'b1 && c < 40000);
        tmo(c >= 40000);
    endtask
    // Clock setup only while the driver is stopped
    task automatic setclk(input logic [31:0] cfg);
        apb(1'b1, slfc_pkg::OFF_CTRL, 32'h0);
        apb(1'b1, slfc_pkg::OFF_CLKCFG, cfg);
        apb(1'b1, slfc_pkg::OFF_CTRL, 32'h1);
    endtask
    // Main sequence
    initial begin
        repeat (20) @(posedge clk_i);
        srst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk(32'(contrast), 32'h1f);
        apb(1'b0, slfc_pkg::OFF_DISP, 32'h0);
        chk(rd, 32'hf80);
        apb(1'b1, slfc_pkg::OFF_DISP, 32'h20);
        repeat (2) @(posedge clk_i);
        chk({ssel, cref, contrast}, 7'h20);
        apb(1'b1, slfc_pkg::OFF_DISP, 32'h40);
        repeat (2) @(posedge clk_i);
        chk({ssel, cref, contrast}, 7'h40);
        apb(1'b0, 12'h0fc, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        $display("Done: register access");
        for (int p = 0; p < 4; p++) begin
            setclk(32'(p));
            wait_ev(0, c);
            wait_ev(0, c);
            chk(c, 64 << p);
        end
        for (int f = 3; f < 8; f += 4) begin
            setclk(32'(f << 2));
            wait_ev(0, c);
            wait_ev(0, c);
            chk(c, 64 * (1 + f));
        end
        for (int b = 0; b < 8; b++) begin
            setclk(32'(b << 5));
            wait_ev(3, c);
            wait_ev(3, c);
            chk(c, 4 << b);
        end
        setclk(32'h0);
        for (int m = 0; m < 6; m++) begin
            apb(1'b1, slfc_pkg::OFF_DISP, 32'(m));
            repeat (2) wait_ev(1, c);
            wait_ev(1, c);
            chk(c, 64 * ticks[m]);
            chk(32'(tpf), ticks[m]);
        end
        apb(1'b1, slfc_pkg::OFF_DISP, 32'h10);
        $display("Done: clocking and frame rate");
        apb(1'b1, slfc_pkg::OFF_IEN, 32'h1);
        for (int p = 0; p < 4; p++) begin
            apb(1'b1, slfc_pkg::OFF_BLINK_ANIMATION_CONTROL, 32'h9 | 32'(p << 1));
            fc_frames(nf);
            chk(nf, 2 << p);
        end
        apb(1'b1, slfc_pkg::OFF_BLINK_ANIMATION_CONTROL, 32'h29);
        fc_frames(nf);
        chk(nf, 6);
        repeat (3) @(posedge clk_i);
        chk(32'(irq), 32'h1);
        apb(1'b0, slfc_pkg::OFF_IF, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, slfc_pkg::OFF_IFC, 32'h1);
        repeat (2) @(posedge clk_i);
        chk(32'(irq), 32'h0);
        apb(1'b1, slfc_pkg::OFF_IEN, 32'h0);
        apb(1'b1, slfc_pkg::OFF_IFS, 32'h1);
        repeat (2) @(posedge clk_i);
        chk(32'(irq), 32'h0);
        $display("Done: frame counter and flag");
        apb(1'b1, slfc_pkg::OFF_BLINK_ANIMATION_CONTROL, 32'h0);
        apb(1'b1, slfc_pkg::OFF_CTRL, 32'h3);
        apb(1'b1, slfc_pkg::OFF_ANIMATION_PATTERN_FIRST, 32'h5a);
        nf = 0;
        for (int i = 0; i < 1500; i++) begin
            @(posedge clk_i);
            if (cev === 1'b1) nf++;
        end
        chk(nf, 0);
        chk(32'(anim_a), 32'h0);
        apb(1'b1, slfc_pkg::OFF_BLINK_ANIMATION_CONTROL, 32'h1);
        wait_ev(2, c);
        repeat (3) @(posedge clk_i);
        chk(32'(anim_a), 32'h5a);
        chk(32'(bact), 32'h1);
        apb(1'b1, slfc_pkg::OFF_CTRL, 32'h5);
        wait_ev(1, c);
        apb(1'b1, slfc_pkg::OFF_ANIMATION_PATTERN_SECOND, 32'hc3);
        repeat (3) @(posedge clk_i);
        chk(32'(anim_b), 32'h0);
        wait_ev(1, c);
        repeat (3) @(posedge clk_i);
        chk(32'(anim_b), 32'hc3);
        $display("Done: update timing");
        apb(1'b1, slfc_pkg::OFF_CTRL, 32'h9);
        apb(1'b1, slfc_pkg::OFF_SEGD0, 32'he4e4e4e4);
        apb(1'b1, 12'h04c, 32'h1b1b1b1b);
        apb(1'b1, slfc_pkg::OFF_COMMON_LEVEL_DATA, 32'h3);
        repeat (2) wait_ev(0, c);
        repeat (3) @(posedge clk_i);
        chk(seg_lvl[31:0], 32'he4e4e4e4);
        chk(seg_lvl[127:96], 32'h1b1b1b1b);
        chk(com_lvl, 32'h3);
        wait_ev(1, c);
        repeat (2) @(posedge clk_i);
        chk(shown[159:128], 32'h3);
        apb(1'b1, slfc_pkg::OFF_CTRL, 32'h1);
        repeat (2) wait_ev(1, c);
        chk(seg_lvl[31:0], 32'haaaaaaaa);
        $display("Done: direct level control");
        stop_test();
    end
endmodule
`default_nettype wire
